// ===== verilog/ffs_pkg.sv
// shared constants of the flyback fault sequencer
package ffs_pkg;

   // clock and derived period
   localparam int CLK_MHZ = 20;
   localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

   // timing figures in their own units
   localparam int LEB_NS = 250;           // blanking after turn-on
   localparam int SAMPLE_NS = 1850;       // output sample delay after turn-off
   localparam int SSC_DELAY_NS = 3000;    // sense-short sample delay after turn-on
   localparam int BNO_MS = 50;            // brown-out debounce
   localparam int UV_BLANK_MS = 30;       // output under-voltage blank after start

   // cycle counts, least times rounded up
   localparam logic [2:0] LEB_CYCLES = 3'((LEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [5:0] SAMPLE_CYCLES = 6'((SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [6:0] SSC_CYCLES = 7'((SSC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [19:0] BNO_CYCLES_DEF = 20'(BNO_MS * 1000000 / CLK_PERIOD_NS);
   localparam logic [19:0] UV_BLANK_CYCLES_DEF = 20'(UV_BLANK_MS * 1000000 / CLK_PERIOD_NS);

   // consecutive-cycle limits and the probing pulse count
   localparam logic [2:0] FAULT_CYCLES = 3'h6;
   localparam logic [2:0] LINE_GOOD_CYCLES = 3'h4;
   localparam logic [2:0] PROBE_PULSES = 3'h4;

   // synchronised input indices
   localparam int IN_FB_LOW = 0;
   localparam int IN_MAINT = 1;
   localparam int IN_PEAK = 2;
   localparam int IN_CLIM = 3;
   localparam int IN_LINE_GOOD = 4;
   localparam int IN_BROWN = 5;
   localparam int IN_OUT_OV = 6;
   localparam int IN_OUT_UV = 7;
   localparam int IN_FAST_OC = 8;
   localparam int IN_SENSE_SHORT = 9;
   localparam int IN_SUPPLY_OV = 10;
   localparam int IN_HOT = 11;
   localparam int IN_COOL = 12;
   localparam int IN_PIN_FAULT = 13;
   localparam int IN_SUPPLY_UNDERVOLTAGE_LOCKOUT = 14;
   localparam int NUM_IN = 15;

   // latching fault indices
   localparam int F_OUT_OV = 0;
   localparam int F_OUT_UV = 1;
   localparam int F_FAST_OC = 2;
   localparam int F_SENSE_SHORT = 3;
   localparam int F_SUPPLY_OV = 4;
   localparam int NUM_F = 5;

   // register map (byte addresses)
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] PERIOD_ADDR = 8'h04;
   localparam logic [7:0] MAXON_ADDR = 8'h08;
   localparam logic [7:0] STATUS_ADDR = 8'h0c;

   // reset values
   localparam logic CTRL_EN_RESET = 1'b1;
   localparam logic [15:0] PERIOD_RESET = 16'h00c8;
   localparam logic [15:0] MAXON_RESET = 16'h0064;

   // status field positions
   localparam int ST_STATE_LSB = 0;
   localparam int ST_GATE_BIT = 5;
   localparam int ST_OTP_BIT = 6;
   localparam int ST_PROBE_LSB = 8;
   localparam int ST_CAUSE_LSB = 12;

   // sequencer states
   typedef enum logic [4:0] {
      ST_OFF = 5'h01,
      ST_PROBE = 5'h02,
      ST_RUN = 5'h04,
      ST_BROWN = 5'h08,
      ST_LATCH = 5'h10
   } ffs_state_t;

endpackage

// ===== verilog/ffs_cycle_count.sv
`timescale 1ns/1ps
`default_nettype none
// counts consecutive switching cycles in which a condition holds
module ffs_cycle_count #(
   parameter logic [2:0] LIMIT = 3'h6
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // cycle event and condition
   input wire logic clear_in,
   input wire logic strobe_in,
   input wire logic cond_in,
   // limit reached
   output logic hit_out
);

   logic [2:0] count_reg;   // consecutive cycles seen
   logic [2:0] count_next;
   logic hit_next;

   // next count: saturate at the limit, drop to zero on a clean cycle
   always_comb begin
      count_next = count_reg;
      if (clear_in) begin
         count_next = 3'h0;
      end else if (strobe_in) begin
         if (!cond_in) begin
            count_next = 3'h0;
         end else if (count_reg != LIMIT) begin
            count_next = count_reg + 3'h1;
         end
      end
      hit_next = (count_next == LIMIT);
   end

   // register count and hit flag
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         count_reg <= 3'h0;
         hit_out <= 1'b0;
      end else begin
         count_reg <= count_next;
         hit_out <= hit_next;
      end
   end

endmodule
`default_nettype wire

// ===== verilog/ffs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module ffs_sequencer import ffs_pkg::*; #(
   parameter logic [19:0] BNO_DEBOUNCE_CYCLES = BNO_CYCLES_DEF,
   parameter logic [19:0] UV_BLANK_CYCLES = UV_BLANK_CYCLES_DEF
) (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [7:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // comparator flags (asynchronous)
   input wire logic fb_low_in,
   input wire logic maintain_in,
   input wire logic peak_current_in,
   input wire logic current_limit_in,
   input wire logic line_good_in,
   input wire logic brown_out_in,
   input wire logic output_overvoltage_trip_in,
   input wire logic output_undervoltage_in,
   input wire logic fast_overcurrent_trip_in,
   input wire logic sense_short_trip_in,
   input wire logic supply_overvoltage_trip_in,
   input wire logic temp_hot_in,
   input wire logic temp_cool_in,
   input wire logic pin_fault_in,
   input wire logic supply_undervoltage_lockout_in,
   // switch drive
   output logic gate_drive_out
);

   logic [NUM_IN-1:0] raw;       // flags gathered by index
   logic [NUM_IN-1:0] s1_reg;    // synchroniser stages
   logic [NUM_IN-1:0] s2_reg;
   logic [NUM_IN-1:0] s3_reg;
   logic [NUM_IN-1:0] q_reg;     // qualified flags
   logic [NUM_IN-1:0] q_next;

   assign raw = {supply_undervoltage_lockout_in, pin_fault_in, temp_cool_in, temp_hot_in,
                 supply_overvoltage_trip_in, sense_short_trip_in, fast_overcurrent_trip_in,
                 output_undervoltage_in, output_overvoltage_trip_in, brown_out_in,
                 line_good_in, current_limit_in, peak_current_in, maintain_in, fb_low_in};

   // three-stage synchroniser per flag, change taken when stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
         always_comb begin
            q_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : q_reg[gi];
         end
         always_ff @(posedge ref_clk_in or posedge rst_in) begin
            if (rst_in) begin
               s1_reg[gi] <= 1'b0;
               s2_reg[gi] <= 1'b0;
               s3_reg[gi] <= 1'b0;
               q_reg[gi] <= (gi == IN_SUPPLY_UNDERVOLTAGE_LOCKOUT);
            end else begin
               s1_reg[gi] <= raw[gi];
               s2_reg[gi] <= s1_reg[gi];
               s3_reg[gi] <= s2_reg[gi];
               q_reg[gi] <= q_next[gi];
            end
         end
      end
   endgenerate

   // register state
   logic ctrl_en_reg;          // software switching enable
   logic ctrl_en_next;
   logic [15:0] period_reg;    // switching period in cycles
   logic [15:0] period_next;
   logic [15:0] maxon_reg;     // longest on-time in cycles
   logic [15:0] maxon_next;
   logic [31:0] prdata_next;
   logic pready_next;
   logic pslverr_next;

   // sequencer state
   ffs_state_t state_reg;
   ffs_state_t state_next;
   logic gate_reg, gate_next;
   logic [15:0] per_cnt_reg, per_cnt_next;   // period countdown
   logic [15:0] on_cnt_reg, on_cnt_next;     // on-time count
   logic [2:0] leb_cnt_reg, leb_cnt_next;    // leading-edge blank
   logic [5:0] samp_cnt_reg, samp_cnt_next;  // output sample delay
   logic [6:0] ssc_cnt_reg, ssc_cnt_next;    // sense-short sample delay
   logic [19:0] bno_cnt_reg, bno_cnt_next;   // brown-out debounce
   logic [19:0] blank_cnt_reg, blank_cnt_next; // output UV blank
   logic [2:0] probe_cnt_reg, probe_cnt_next;  // probing pulses issued
   logic otp_reg, otp_next;                  // over-temperature shutdown
   logic [NUM_F-1:0] cause_reg, cause_next;  // latched fault causes
   logic foc_seen_reg, foc_seen_next;        // fast over-current in this pulse
   logic line_seen_reg, line_seen_next;      // line good in this pulse
   logic maint_prev_reg;                     // maintain edge detector

   // decoded conditions
   logic supply_undervoltage_lockout, run, probe, allow_base, maint_rise;
   logic start_normal, start_maint, pulse_start, pulse_end;
   logic samp_strobe, ssc_strobe, bni_hit, latch_hit;
   logic [NUM_F-1:0] f_strobe, f_cond, f_hit;

   assign supply_undervoltage_lockout = q_reg[IN_SUPPLY_UNDERVOLTAGE_LOCKOUT];
   assign run = (state_reg == ST_RUN);
   assign probe = (state_reg == ST_PROBE);
   assign maint_rise = q_reg[IN_MAINT] && !maint_prev_reg;
   // drive permitted only when enabled, cool, pins sound and sequenced on
   assign allow_base = ctrl_en_reg && !otp_reg && !q_reg[IN_PIN_FAULT] && (run || probe);
   // oscillator pulse: probing, or running with feedback above the floor
   assign start_normal = (per_cnt_reg == 16'h0) && allow_base && !gate_reg &&
                         (probe || (run && !q_reg[IN_FB_LOW]));
   // maintain pulse regardless of feedback
   assign start_maint = run && allow_base && maint_rise && !gate_reg;
   assign pulse_start = start_normal || start_maint;
   // current comparators only count once the blank has run out
   assign pulse_end = gate_reg && (!allow_base || (on_cnt_reg >= maxon_reg) ||
                      ((leb_cnt_reg == 3'h0) && (q_reg[IN_PEAK] || q_reg[IN_CLIM])));
   assign samp_strobe = (samp_cnt_reg == 6'h1);
   assign ssc_strobe = (ssc_cnt_reg == 7'h1);

   // per-fault cycle events and conditions
   assign f_strobe[F_OUT_OV] = samp_strobe;
   assign f_strobe[F_OUT_UV] = samp_strobe;
   assign f_strobe[F_FAST_OC] = pulse_end;
   assign f_strobe[F_SENSE_SHORT] = ssc_strobe;
   assign f_strobe[F_SUPPLY_OV] = pulse_end;
   assign f_cond[F_OUT_OV] = q_reg[IN_OUT_OV];
   assign f_cond[F_OUT_UV] = q_reg[IN_OUT_UV] && (blank_cnt_reg == 20'h0);
   assign f_cond[F_FAST_OC] = foc_seen_reg || q_reg[IN_FAST_OC];
   assign f_cond[F_SENSE_SHORT] = q_reg[IN_SENSE_SHORT];
   assign f_cond[F_SUPPLY_OV] = q_reg[IN_SUPPLY_OV];

   // six-cycle counters for every latching fault
   generate
      for (gi = 0; gi < NUM_F; gi++) begin : g_fault
         ffs_cycle_count #(.LIMIT(FAULT_CYCLES)) u_cnt (
            .ref_clk_in(ref_clk_in),
            .rst_in(rst_in),
            .clear_in(supply_undervoltage_lockout),
            .strobe_in(f_strobe[gi]),
            .cond_in(f_cond[gi]),
            .hit_out(f_hit[gi])
         );
      end
   endgenerate
   assign latch_hit = |f_hit;

   // line-good counter over probing pulses
   ffs_cycle_count #(.LIMIT(LINE_GOOD_CYCLES)) u_line_good (
      .ref_clk_in(ref_clk_in),
      .rst_in(rst_in),
      .clear_in(!probe),
      .strobe_in(pulse_end && probe),
      .cond_in(line_seen_reg || q_reg[IN_LINE_GOOD]),
      .hit_out(bni_hit)
   );

   // sequencer next-state and timers
   always_comb begin
      state_next = state_reg;
      gate_next = gate_reg;
      on_cnt_next = on_cnt_reg;
      cause_next = cause_reg;
      probe_cnt_next = probe_cnt_reg;
      foc_seen_next = foc_seen_reg || (gate_reg && q_reg[IN_FAST_OC]);
      line_seen_next = line_seen_reg || (gate_reg && q_reg[IN_LINE_GOOD]);
      // interval counters count down to zero
      leb_cnt_next = (leb_cnt_reg != 3'h0) ? leb_cnt_reg - 3'h1 : 3'h0;
      samp_cnt_next = (samp_cnt_reg != 6'h0) ? samp_cnt_reg - 6'h1 : 6'h0;
      ssc_cnt_next = (ssc_cnt_reg != 7'h0) ? ssc_cnt_reg - 7'h1 : 7'h0;
      blank_cnt_next = (blank_cnt_reg != 20'h0) ? blank_cnt_reg - 20'h1 : 20'h0;
      per_cnt_next = (per_cnt_reg != 16'h0) ? per_cnt_reg - 16'h1 : 16'h0;
      // brown-out must persist without a break
      bno_cnt_next = (run && q_reg[IN_BROWN]) ? bno_cnt_reg + 20'h1 : 20'h0;
      // hysteresis window on temperature
      if (q_reg[IN_HOT]) begin
         otp_next = 1'b1;
      end else if (q_reg[IN_COOL]) begin
         otp_next = 1'b0;
      end else begin
         otp_next = otp_reg;
      end
      // gate edges
      if (pulse_start) begin
         gate_next = 1'b1;
         on_cnt_next = 16'h0;
         leb_cnt_next = LEB_CYCLES;
         ssc_cnt_next = SSC_CYCLES;
         foc_seen_next = 1'b0;
         line_seen_next = 1'b0;
         if (start_normal) begin
            per_cnt_next = period_reg - 16'h1;
         end
         if (probe && probe_cnt_reg != PROBE_PULSES) begin
            probe_cnt_next = probe_cnt_reg + 3'h1;
         end
      end else if (pulse_end) begin
         gate_next = 1'b0;
         samp_cnt_next = SAMPLE_CYCLES;
      end else if (gate_reg) begin
         on_cnt_next = on_cnt_reg + 16'h1;
      end
      // sequencing
      if (supply_undervoltage_lockout) begin
         state_next = ST_OFF;
         gate_next = 1'b0;
         cause_next = '0;
      end else begin
         unique case (state_reg)
            ST_OFF: begin
               state_next = ST_PROBE;
               probe_cnt_next = 3'h0;
               blank_cnt_next = UV_BLANK_CYCLES;
            end
            ST_PROBE: begin
               if (latch_hit) begin
                  state_next = ST_LATCH;
               end else if (bni_hit) begin
                  state_next = ST_RUN;
               end
            end
            ST_RUN: begin
               if (latch_hit) begin
                  state_next = ST_LATCH;
               end else if (q_reg[IN_BROWN] && bno_cnt_reg == BNO_DEBOUNCE_CYCLES - 20'h1) begin
                  state_next = ST_BROWN;
               end
            end
            ST_BROWN: begin
               if (!q_reg[IN_BROWN]) begin
                  state_next = ST_PROBE;
                  probe_cnt_next = 3'h0;
               end
            end
            ST_LATCH: begin
               state_next = ST_LATCH;
            end
            default: begin
               state_next = ST_OFF;
            end
         endcase
         if (probe || run) begin
            cause_next = cause_reg | f_hit;
         end
      end
   end

   // sequencer registers
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= ST_OFF;
         gate_reg <= 1'b0;
         per_cnt_reg <= 16'h0;
         on_cnt_reg <= 16'h0;
         leb_cnt_reg <= 3'h0;
         samp_cnt_reg <= 6'h0;
         ssc_cnt_reg <= 7'h0;
         bno_cnt_reg <= 20'h0;
         blank_cnt_reg <= 20'h0;
         probe_cnt_reg <= 3'h0;
         otp_reg <= 1'b0;
         cause_reg <= '0;
         foc_seen_reg <= 1'b0;
         line_seen_reg <= 1'b0;
         maint_prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         gate_reg <= gate_next;
         per_cnt_reg <= per_cnt_next;
         on_cnt_reg <= on_cnt_next;
         leb_cnt_reg <= leb_cnt_next;
         samp_cnt_reg <= samp_cnt_next;
         ssc_cnt_reg <= ssc_cnt_next;
         bno_cnt_reg <= bno_cnt_next;
         blank_cnt_reg <= blank_cnt_next;
         probe_cnt_reg <= probe_cnt_next;
         otp_reg <= otp_next;
         cause_reg <= cause_next;
         foc_seen_reg <= foc_seen_next;
         line_seen_reg <= line_seen_next;
         maint_prev_reg <= q_reg[IN_MAINT];
      end
   end
   assign gate_drive_out = gate_reg;

   // apb slave: one access cycle, writes land on the completing edge
   always_comb begin
      ctrl_en_next = ctrl_en_reg;
      period_next = period_reg;
      maxon_next = maxon_reg;
      prdata_next = 32'h0;
      pslverr_next = 1'b0;
      pready_next = psel_in && !penable_in;
      if (psel_in && !penable_in) begin
         unique case (paddr_in)
            CTRL_ADDR: prdata_next = {31'h0, ctrl_en_reg};
            PERIOD_ADDR: prdata_next = {16'h0, period_reg};
            MAXON_ADDR: prdata_next = {16'h0, maxon_reg};
            STATUS_ADDR: begin
               prdata_next[ST_STATE_LSB +: 5] = state_reg;
               prdata_next[ST_GATE_BIT] = gate_reg;
               prdata_next[ST_OTP_BIT] = otp_reg;
               prdata_next[ST_PROBE_LSB +: 3] = probe_cnt_reg;
               prdata_next[ST_CAUSE_LSB +: NUM_F] = cause_reg;
            end
            default: pslverr_next = 1'b1;
         endcase
      end
      if (psel_in && penable_in && pready_out && pwrite_in) begin
         if (paddr_in == CTRL_ADDR) begin
            ctrl_en_next = pwdata_in[0];
         end else if (paddr_in == PERIOD_ADDR) begin
            period_next = pwdata_in[15:0];
         end else if (paddr_in == MAXON_ADDR) begin
            maxon_next = pwdata_in[15:0];
         end
      end
   end

   // apb registers
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_en_reg <= CTRL_EN_RESET;
         period_reg <= PERIOD_RESET;
         maxon_reg <= MAXON_RESET;
         prdata_out <= 32'h0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         ctrl_en_reg <= ctrl_en_next;
         period_reg <= period_next;
         maxon_reg <= maxon_next;
         prdata_out <= prdata_next;
         pready_out <= pready_next;
         pslverr_out <= pslverr_next;
      end
   end

   // checks
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);

   chk_fb_stops_normal: assert property (
      $rose(gate_reg) && $past(run) && $past(q_reg[IN_FB_LOW]) |-> $past(maint_rise))
      else $error("pulse started with feedback low and no maintain request");
   chk_maint_forces: assert property (
      start_maint && !supply_undervoltage_lockout |=> gate_reg && leb_cnt_reg == LEB_CYCLES)
      else $error("maintain request did not start a pulse");
   chk_leb_holds: assert property (
      gate_reg && leb_cnt_reg != 3'h0 && allow_base && !supply_undervoltage_lockout && on_cnt_reg < maxon_reg
      |=> gate_reg)
      else $error("pulse ended inside leading-edge blank");
   chk_run_after_good: assert property (
      $rose(run) |-> $past(bni_hit) && probe_cnt_reg == PROBE_PULSES)
      else $error("normal switching without four line-good cycles");
   chk_sample_delay: assert property (
      $fell(gate_reg) |-> ##36 (samp_strobe || $rose(gate_reg) || supply_undervoltage_lockout))
      else $error("output sample not taken at the delay after turn-off");
   chk_latch_holds: assert property (
      state_reg == ST_LATCH && !supply_undervoltage_lockout |=> state_reg == ST_LATCH && !gate_reg)
      else $error("latched shutdown left without supply lockout");
   chk_uv_blanked: assert property (
      blank_cnt_reg != 20'h0 |=> !f_hit[F_OUT_UV])
      else $error("output under-voltage counted during blank");
   chk_hot_stops: assert property (
      otp_reg |=> !gate_reg)
      else $error("drive while over-temperature");
   chk_lockout_off: assert property (
      supply_undervoltage_lockout |=> !gate_reg && state_reg == ST_OFF)
      else $error("drive active under supply lockout");

endmodule
`default_nettype wire

// ===== verification/ffs_switch_model.sv
`timescale 1ns/1ps
`default_nettype none
// power switch and transformer seen from the sense and demag pins
module ffs_switch_model (
   // clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_in,
   // gate drive and line conditions
   input wire logic gate_in,
   input wire logic line_ok_in,
   input wire logic [7:0] on_len_in,
   // comparator flags back to the sequencer
   output logic peak_out,
   output logic limit_out,
   output logic line_good_out
);
   logic [7:0] on_reg; // cycles since switch turn-on
   // ramp of primary current while the switch conducts
   always_ff @(posedge ref_clk_in or posedge rst_in) begin
      if (rst_in) begin
         on_reg <= 8'h00;
      end else if (gate_in) begin
         on_reg <= (on_reg == 8'hff) ? on_reg : on_reg + 8'h01;
      end else begin
         on_reg <= 8'h00;
      end
   end
   // no current flows with the switch off, so every flag drops
   assign peak_out = gate_in && (on_reg >= on_len_in);
   assign limit_out = gate_in && ({1'b0, on_reg} >= {1'b0, on_len_in} + 9'h004);
   assign line_good_out = gate_in && line_ok_in;
endmodule
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, g, e) begin compares++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb import ffs_pkg::*;;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] pa = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic prdy, perr, er, gate, peak, lim, lg;
   logic fb = 1'b0, mnt = 1'b0, hot = 1'b0, cool = 1'b1, pf = 1'b0;
   logic supply_undervoltage_lockout = 1'b0, fo = 1'b0, lok = 1'b0, bo = 1'b0, ov = 1'b0;
   logic [7:0] onl = 8'h00;
   int errors = 0, compares = 0, pulses = 0, width = 0, run = 0;
   ffs_sequencer #(.BNO_DEBOUNCE_CYCLES(20'h0c8), .UV_BLANK_CYCLES(20'h064)) i_ffs_sequencer (
      .ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
      .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
      .pready_out(prdy), .pslverr_out(perr), .fb_low_in(fb), .maintain_in(mnt),
      .peak_current_in(peak), .current_limit_in(lim), .line_good_in(lg),
      .brown_out_in(bo), .output_overvoltage_trip_in(ov),
      .output_undervoltage_in(1'b0), .fast_overcurrent_trip_in(fo),
      .sense_short_trip_in(1'b0), .supply_overvoltage_trip_in(1'b0),
      .temp_hot_in(hot), .temp_cool_in(cool), .pin_fault_in(pf),
      .supply_undervoltage_lockout_in(supply_undervoltage_lockout), .gate_drive_out(gate));
   ffs_switch_model i_ffs_switch_model (.ref_clk_in(clk), .rst_in(rst),
      .gate_in(gate), .line_ok_in(lok), .on_len_in(onl), .peak_out(peak),
      .limit_out(lim), .line_good_out(lg));
   initial begin
      forever #25 clk = ~clk;
   end
   // count finished pulses and keep the last width
   always @(posedge clk) begin
      if (gate === 1'b1) begin
         run++;
      end else begin
         if (run > 0) begin
            width = run;
            pulses++;
         end
         run = 0;
      end
   end
   // one apb transfer: an idle edge, the setup edge, then access until pready is high at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1; pen <= 1'b0; pwr <= w; pa <= a; pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (prdy !== 1'b1 && n < 20);
      // read data and error are taken at the edge that completes the access
      rd = prd;
      er = perr;
      if (prdy !== 1'b1) errors++;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task expect_reg(input string n, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(n, rd, e)
   endtask
   task wait_state(input logic [4:0] s);
      int n;
      n = 0;
      do begin
         apb(1'b0, STATUS_ADDR, 32'h0);
         n++;
      end while (rd[4:0] !== s && n < 400);
      `CHK("state", rd[4:0], s)
   endtask
   task wait_pulses(input int k);
      int t;
      t = pulses + k;
      repeat (5000) if (pulses < t) @(posedge clk);
      `CHK("pulses came", pulses >= t, 1'b1)
   endtask
   // let a running pulse finish, then expect silence
   task quiet(input int cyc);
      int p;
      repeat (40) @(posedge clk);
      p = pulses;
      repeat (cyc) @(posedge clk);
      `CHK("no pulses", pulses == p, 1'b1)
   endtask
   task wrap_up;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      errors++;
      wrap_up;
   end
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      expect_reg("ctrl", CTRL_ADDR, 32'h1);
      expect_reg("period", PERIOD_ADDR, 32'(PERIOD_RESET));
      expect_reg("maxon", MAXON_ADDR, 32'(MAXON_RESET));
      apb(1'b0, 8'h10, 32'h0);
      `CHK("slverr", er, 1'b1)
      apb(1'b1, PERIOD_ADDR, 32'h50);
      expect_reg("period wr", PERIOD_ADDR, 32'h50);
      wait_pulses(6);
      apb(1'b0, STATUS_ADDR, 32'h0);
      `CHK("probe hold", rd[4:0], ST_PROBE)
      lok <= 1'b1;
      wait_state(ST_RUN);
      `CHK("probe count", rd[10:8], 3'h4)
      wait_pulses(2);
      `CHK("blank width", width > 32'(LEB_CYCLES), 1'b1)
      onl <= 8'h14;
      wait_pulses(2);
      `CHK("slow width", width >= 20, 1'b1)
      fb <= 1'b1;
      quiet(300);
      mnt <= 1'b1;
      wait_pulses(1);
      quiet(300);
      mnt <= 1'b0;
      fb <= 1'b0;
      hot <= 1'b1;
      cool <= 1'b0;
      quiet(300);
      apb(1'b0, STATUS_ADDR, 32'h0);
      `CHK("otp flag", rd[ST_OTP_BIT], 1'b1)
      hot <= 1'b0;
      cool <= 1'b1;
      wait_pulses(2);
      pf <= 1'b1;
      quiet(300);
      pf <= 1'b0;
      wait_pulses(1);
      fo <= 1'b1;
      wait_state(ST_LATCH);
      `CHK("cause", rd[16:12], 5'h04)
      fo <= 1'b0;
      quiet(300);
      supply_undervoltage_lockout <= 1'b1;
      quiet(100);
      supply_undervoltage_lockout <= 1'b0;
      wait_state(ST_PROBE);
      `CHK("cause clear", rd[16:12], 5'h00)
      wait_state(ST_RUN);
      // brown-out must persist for the whole debounce before it stops the drive
      bo <= 1'b1;
      repeat (150) @(posedge clk);
      apb(1'b0, STATUS_ADDR, 32'h0);
      `CHK("debounce", rd[4:0], ST_RUN)
      wait_state(ST_BROWN);
      quiet(100);
      bo <= 1'b0;
      wait_state(ST_RUN);
      // sampled output over-voltage in six cycles latches off
      ov <= 1'b1;
      wait_state(ST_LATCH);
      `CHK("ov cause", rd[16:12], 5'h01)
      wrap_up;
   end
endmodule
`default_nettype wire
